//--- verilog/timer_one_pkg.sv
package timer_one_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] CTRL_ADDR     = 8'h10;  // control register
  localparam logic [7:0] CNT_LO_ADDR   = 8'h00;  // count low byte
  localparam logic [7:0] CNT_HI_ADDR   = 8'h04;  // count high byte
  localparam logic [7:0] FLAG_ADDR     = 8'h08;  // peripheral flag register
  localparam logic [7:0] ENABLE_ADDR   = 8'h0C;  // peripheral enable register

  // control register field positions
  localparam int CTRL_ON_BIT   = 0;  // count on
  localparam int CTRL_CS_BIT   = 1;  // clock source select
  localparam int CTRL_SYNC_BIT = 2;  // no sync select
  localparam int CTRL_OSC_BIT  = 3;  // oscillator enable
  localparam int CTRL_PS_LO    = 4;  // prescale select low bit
  localparam int CTRL_PS_HI    = 5;  // prescale select high bit
  localparam logic [7:0] CTRL_WMASK  = 8'h3F;  // implemented control bits
  localparam logic [7:0] CTRL_RESET  = 8'h00;  // control value after reset
  localparam int FLAG_BIT      = 0;  // overflow flag position
  localparam int IRQEN_BIT     = 0;  // overflow enable position

  // timing: core clock divided by four gives the instruction cycle
  localparam int CORE_DIV      = 4;
  localparam logic [1:0] QPHASE_LAST = 2'(CORE_DIV - 1);
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL1  = 16'hFFFF;
  localparam logic [2:0]  PRE_RESET   = 3'h0;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // whole block state
  typedef struct packed {
    logic [7:0]  ctrl;     // control register
    logic [15:0] count;    // counter pair
    logic        flag;     // overflow flag
    logic        irqEn;    // overflow enable
    logic [2:0]  pre;      // prescaler count
    logic [1:0]  qPhase;   // instruction cycle phase
    logic        extSync1; // synchroniser stage one
    logic        extSync2; // synchroniser stage two
    logic        extPrev;  // previous sampled external level
    logic [31:0] rdata;    // read data register
  } tmr_state_t;

endpackage : timer_one_pkg

//--- verilog/timer_one_counter.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - count held in readable writable high, low bytes
// - counts up from zero, wraps after all ones
// - wrap sets sticky flag until software clears
// - interrupt request only when overflow enable set
// - clock select bit chooses timer or counter
// - timer mode advances once per instruction cycle
// - counter mode advances on external rising edges
// - counts only while on bit set
// - compare unit input clears the counter
// - oscillator enable makes both pins inputs
// - upper two control bits read zero
// - prescale field divides by one, two, four, eight
// - clock select clear means timer mode
// - timer input is core clock over four
// - sync bit ignored in timer mode
// - counter mode sync bit bypasses synchroniser; the code still passes the level through stage one and skips only stage two
// - compare trigger clears, no flag; write wins
// - count byte writes clear prescaler
// - oscillator enable picks oscillator input pin
module timer_one_counter
  import timer_one_pkg::*;
(
  input  wire logic        clk_sys,      // core clock
  input  wire logic        rstn,         // asynchronous reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic             pready,       // apb ready
  output logic [31:0]      prdata,       // apb read data
  output logic             pslverr,      // apb error on unmapped address
  input  wire logic        oscInPin,     // oscillator input pin level
  input  wire logic        extClockPin,  // clock-input pin level
  output logic             oscOutPinOe,  // clock-input pin drive enable
  output logic             oscInPinOe,   // oscillator input pin drive enable
  input  wire logic        compareReset, // compare unit special event trigger
  output logic             overflowIrq,  // overflow interrupt request
  output logic [15:0]      countValue    // counter value for compare unit
);

  apb_req_t   req;        // bundled bus request
  tmr_state_t state_ff;   // registered state
  tmr_state_t nxt_state;  // next state

  // prescale ratio decode: returns the terminal prescaler count
  function automatic logic [2:0] pre_last(input logic [1:0] ps);
    case (ps)
      2'h3:    pre_last = 3'h7;
      2'h2:    pre_last = 3'h3;
      2'h1:    pre_last = 3'h1;
      default: pre_last = 3'h0;
    endcase
  endfunction : pre_last

  // address hit check
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  logic accPhase;  // access phase of a transfer
  logic wrAcc;     // write taking effect now
  logic mapped;    // address decodes to a register
  logic wrLo;      // write to count low byte
  logic wrHi;      // write to count high byte
  logic tick;      // raw counter input tick before prescale
  logic preOut;    // prescaler output tick
  logic extLevel;  // chosen external clock level
  logic extSeen;   // level used for edge detection
  logic inc;       // count increments this cycle

  // bus request bundle and decode
  always_comb begin
    req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    accPhase = req.psel && req.penable;
    mapped = is_addr(req.paddr, CTRL_ADDR) || is_addr(req.paddr, CNT_LO_ADDR) ||
             is_addr(req.paddr, CNT_HI_ADDR) || is_addr(req.paddr, FLAG_ADDR) ||
             is_addr(req.paddr, ENABLE_ADDR);
    wrAcc = accPhase && req.pwrite && mapped;
    wrLo = wrAcc && is_addr(req.paddr, CNT_LO_ADDR);
    wrHi = wrAcc && is_addr(req.paddr, CNT_HI_ADDR);
  end

  // counter input selection and prescaler
  always_comb begin
    // external source pin choice
    extLevel = state_ff.ctrl[CTRL_OSC_BIT] ? oscInPin : extClockPin;
    // two-stage synchronised path or single-stage path from synchroniser stage one
    extSeen = state_ff.ctrl[CTRL_SYNC_BIT] ? state_ff.extSync1 : state_ff.extSync2;
    if (!state_ff.ctrl[CTRL_CS_BIT]) begin
      tick = (state_ff.qPhase == QPHASE_LAST);
    end else begin
      tick = extSeen && !state_ff.extPrev;
    end
    preOut = tick && (state_ff.pre == pre_last(state_ff.ctrl[CTRL_PS_HI:CTRL_PS_LO]));
    inc = state_ff.ctrl[CTRL_ON_BIT] && preOut;
  end

  // next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_state.qPhase = state_ff.qPhase + 2'h1;
    nxt_state.extSync1 = extLevel;
    nxt_state.extSync2 = state_ff.extSync1;
    nxt_state.extPrev = extSeen;
    // prescaler runs on every input tick while on
    if (wrLo || wrHi) begin
      nxt_state.pre = PRE_RESET;
    end else if (state_ff.ctrl[CTRL_ON_BIT] && tick) begin
      nxt_state.pre = preOut ? PRE_RESET : state_ff.pre + 3'h1;
    end
    // count: increment, wrap and flag
    if (compareReset) begin
      nxt_state.count = COUNT_RESET;
    end else if (inc) begin
      nxt_state.count = state_ff.count + 16'h0001;
      // a same-cycle count write replaces the increment, so no wrap happens
      if (state_ff.count == COUNT_ALL1 && !wrLo && !wrHi) begin
        nxt_state.flag = 1'b1;
      end
    end
    // software writes take precedence over trigger and increment
    if (wrLo) begin
      nxt_state.count[7:0] = req.pwdata[7:0];
    end
    if (wrHi) begin
      nxt_state.count[15:8] = req.pwdata[7:0];
    end
    if (wrAcc && is_addr(req.paddr, CTRL_ADDR)) begin
      nxt_state.ctrl = req.pwdata[7:0] & CTRL_WMASK;
    end
    if (wrAcc && is_addr(req.paddr, ENABLE_ADDR)) begin
      nxt_state.irqEn = req.pwdata[IRQEN_BIT];
    end
    // flag clear by software loses to a simultaneous wrap
    if (wrAcc && is_addr(req.paddr, FLAG_ADDR)) begin
      nxt_state.flag = req.pwdata[FLAG_BIT] ||
                       (inc && !compareReset && state_ff.count == COUNT_ALL1);
    end
    // read data capture in setup phase
    nxt_state.rdata = 32'h0000_0000;
    if (req.psel && !req.penable && !req.pwrite) begin
      case (1'b1)
        is_addr(req.paddr, CTRL_ADDR):   nxt_state.rdata[7:0] = state_ff.ctrl & CTRL_WMASK;
        is_addr(req.paddr, CNT_LO_ADDR): nxt_state.rdata[7:0] = state_ff.count[7:0];
        is_addr(req.paddr, CNT_HI_ADDR): nxt_state.rdata[7:0] = state_ff.count[15:8];
        is_addr(req.paddr, FLAG_ADDR):   nxt_state.rdata[FLAG_BIT] = state_ff.flag;
        is_addr(req.paddr, ENABLE_ADDR): nxt_state.rdata[IRQEN_BIT] = state_ff.irqEn;
        default:                         nxt_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '{ctrl: CTRL_RESET, count: COUNT_RESET, flag: 1'b0, irqEn: 1'b0,
                    pre: PRE_RESET, qPhase: 2'h0, extSync1: 1'b0, extSync2: 1'b0,
                    extPrev: 1'b0, rdata: 32'h0000_0000};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs
  always_comb begin
    pready = 1'b1;                    // zero wait states
    pslverr = accPhase && !mapped;    // unmapped address errors
    prdata = state_ff.rdata;
    overflowIrq = state_ff.flag && state_ff.irqEn;
    oscInPinOe = 1'b0;
    oscOutPinOe = 1'b0;  // no oscillator drive: both pins stay inputs
    countValue = state_ff.count;
  end

  // counting checks

  // wrap sets the flag and clears the count on the next edge
  wrap_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (inc && !compareReset && !wrLo && !wrHi && state_ff.count == COUNT_ALL1)
      |=> (state_ff.flag && state_ff.count == COUNT_RESET))
    else $error("wrap missed");

  // off means count holds
  hold_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!state_ff.ctrl[CTRL_ON_BIT] && !compareReset && !wrLo && !wrHi)
      |=> $stable(state_ff.count))
    else $error("count moved while off");

  // each increment adds exactly one
  count_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (inc && !compareReset && !wrLo && !wrHi)
      |=> (state_ff.count == $past(state_ff.count) + 16'h0001))
    else $error("count step wrong");

  // no increment, trigger or write means no change
  no_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!inc && !compareReset && !wrLo && !wrHi)
      |=> $stable(state_ff.count))
    else $error("count drifted");

  // timer mode increments once per four cycles at 1:1
  timer_rate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (inc && !state_ff.ctrl[CTRL_CS_BIT]) |=> !inc [*3])
    else $error("timer too fast");

  // timer increments only on the last core phase
  timer_phase_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (inc && !state_ff.ctrl[CTRL_CS_BIT]) |-> (state_ff.qPhase == QPHASE_LAST))
    else $error("timer off phase");

  // counter mode needs a seen rising edge
  ext_edge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_ff.ctrl[CTRL_CS_BIT] && !extSeen) |-> !inc)
    else $error("count without edge");

  // prescaler checks

  // prescale 1:2 in timer mode spaces increments eight cycles apart
  pre_div_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (inc && state_ff.ctrl[CTRL_PS_HI:CTRL_PS_LO] == 2'h1 && !state_ff.ctrl[CTRL_CS_BIT])
      |=> !inc [*7])
    else $error("prescale short");

  // prescaler advances on each input tick below its end
  pre_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_ff.ctrl[CTRL_ON_BIT] && tick && !preOut && !wrLo && !wrHi)
      |=> (state_ff.pre == $past(state_ff.pre) + 3'h1))
    else $error("prescaler stuck");

  // count byte writes clear the prescaler
  pre_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrLo || wrHi) |=> (state_ff.pre == PRE_RESET))
    else $error("prescaler kept");

  // write and trigger checks

  // low write loads the byte
  write_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrLo |=> (state_ff.count[7:0] == $past(pwdata[7:0]) && state_ff.pre == PRE_RESET))
    else $error("low write lost");

  // high write loads the byte
  write_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrHi |=> (state_ff.count[15:8] == $past(pwdata[7:0])))
    else $error("high write lost");

  // trigger clears without flag
  trig_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (compareReset && !wrLo && !wrHi && !(wrAcc && is_addr(req.paddr, FLAG_ADDR)))
      |=> (state_ff.count == COUNT_RESET && state_ff.flag == $past(state_ff.flag)))
    else $error("trigger misbehaved");

  // high write beside a trigger keeps its byte, low byte cleared
  trig_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (compareReset && wrHi)
      |=> (state_ff.count[15:8] == $past(pwdata[7:0]) && state_ff.count[7:0] == 8'h00))
    else $error("write lost to trigger");

  // control write lands masked
  ctrl_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrAcc && is_addr(req.paddr, CTRL_ADDR))
      |=> (state_ff.ctrl == ($past(pwdata[7:0]) & CTRL_WMASK)))
    else $error("control write lost");

  // flag and interrupt checks

  // flag stays set until software writes it
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_ff.flag && !(wrAcc && is_addr(req.paddr, FLAG_ADDR)))
      |=> state_ff.flag)
    else $error("flag dropped");

  // flag rises only on a wrap or a write
  flag_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!state_ff.flag && !(wrAcc && is_addr(req.paddr, FLAG_ADDR)) &&
     !(inc && !compareReset && state_ff.count == COUNT_ALL1))
      |=> !state_ff.flag)
    else $error("flag set without wrap");

  // irq gated by enable
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    overflowIrq |-> (state_ff.irqEn && state_ff.flag))
    else $error("irq ungated");

  // enabled flag raises the request
  irq_on_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_ff.flag && state_ff.irqEn) |-> overflowIrq)
    else $error("irq missing");

  // disabled enable keeps the request low
  irq_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !state_ff.irqEn |-> !overflowIrq)
    else $error("irq while disabled");

  // pin and bus checks

  // both oscillator pins stay inputs
  osc_pins_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!oscInPinOe && !oscOutPinOe))
    else $error("pin driven");

  // upper control bits read zero
  ctrl_upper_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff.ctrl[7:6] == 2'h0)
    else $error("upper bits set");

  // control read returns zero above the implemented bits
  read_ctrl_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accPhase && !req.pwrite && is_addr(req.paddr, CTRL_ADDR))
      |-> (prdata[31:6] == 26'h0))
    else $error("control read upper bits");

  // low byte read returns the count seen in setup
  read_lo_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accPhase && !req.pwrite && is_addr(req.paddr, CNT_LO_ADDR))
      |-> (prdata == {24'h00_0000, $past(state_ff.count[7:0])}))
    else $error("low read wrong");

  // high byte read returns the count seen in setup
  read_hi_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accPhase && !req.pwrite && is_addr(req.paddr, CNT_HI_ADDR))
      |-> (prdata == {24'h00_0000, $past(state_ff.count[15:8])}))
    else $error("high read wrong");

  // unmapped access errors and reads zero
  unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accPhase && !mapped) |-> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  // mapped access never errors
  mapped_ok_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accPhase && mapped) |-> !pslverr)
    else $error("mapped access errored");

  // wrap of the count
  wrap_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    inc && state_ff.count == COUNT_ALL1);
  // counting external edges
  ext_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    inc && state_ff.ctrl[CTRL_CS_BIT]);
  // counting from the oscillator input pin
  osc_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    inc && state_ff.ctrl[CTRL_CS_BIT] && state_ff.ctrl[CTRL_OSC_BIT]);
  // slowest prescale
  pre8_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    inc && state_ff.ctrl[CTRL_PS_HI:CTRL_PS_LO] == 2'h3);
  // trigger beside a count write
  trig_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    compareReset && wrLo);

endmodule : timer_one_counter

//--- verif/ext_clock_source.sv
`timescale 1ns/1ps
module ext_clock_source (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic       toOsc,
  input  wire logic [3:0] edges,
  output logic            oscLevel,
  output logic            extLevel,
  output logic            busy
);
  logic [4:0] halves = 5'h00;  // half periods left in the burst
  logic [1:0] div    = 2'h0;   // four core cycles per half period
  logic       lvl    = 1'b0;   // source level, low while idle
  logic       sel    = 1'b0;   // burst goes to the oscillator pin
  // burst of rising edges, source stands low between bursts
  always @(posedge clk_sys) begin
    if (go && halves == 5'h00) begin
      halves <= {edges, 1'b0};
      sel    <= toOsc;
      div    <= 2'h0;
    end else if (halves != 5'h00) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        lvl    <= ~lvl;
        halves <= halves - 5'h01;
      end
    end
  end
  assign oscLevel = sel & lvl;
  assign extLevel = ~sel & lvl;
  assign busy     = halves != 5'h00;
endmodule : ext_clock_source

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  import timer_one_pkg::*;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        oscInPin, extClockPin, oscOutPinOe, oscInPinOe, compareReset;
  logic        overflowIrq, go, toOsc, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] countValue, cnt, held;
  logic [3:0]  edges;
  int          mismatches, n_checks;
  timer_one_counter dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .oscInPin(oscInPin), .extClockPin(extClockPin),
    .oscOutPinOe(oscOutPinOe), .oscInPinOe(oscInPinOe), .compareReset(compareReset),
    .overflowIrq(overflowIrq), .countValue(countValue));
  ext_clock_source src (.clk_sys(clk_sys), .go(go), .toOsc(toOsc), .edges(edges),
    .oscLevel(oscInPin), .extLevel(extClockPin), .busy(busy));
  // core clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // one bus transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // range compare, exact when both bounds match
  task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, lo);
    end
  endtask : chk
  task rdcnt;
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    cnt[15:8] = rd[7:0];
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    cnt[7:0] = rd[7:0];
  endtask : rdcnt
  task setcnt(input logic [15:0] v);
    apb(1'b1, CNT_HI_ADDR, {24'h0, v[15:8]});
    apb(1'b1, CNT_LO_ADDR, {24'h0, v[7:0]});
  endtask : setcnt
  // burst of rising edges from the partner, then let the synchroniser settle
  task pulse(input logic o, input logic [3:0] n);
    @(posedge clk_sys);
    toOsc <= o; edges <= n; go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    do @(posedge clk_sys); while (busy === 1'b1);
    repeat (6) @(posedge clk_sys);
  endtask : pulse
  task t_regs;
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h00, 32'h00);
    rdcnt();
    chk(cnt, 32'h0, 32'h0);
    chk({oscInPinOe, oscOutPinOe, overflowIrq}, 32'h0, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'hFF);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h3F, 32'h3F);
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, 32'h80000000);
  endtask : t_regs
  task t_timer;
    for (int c = 0; c < 4; c++) begin
      setcnt(16'h0000);
      apb(1'b1, CTRL_ADDR, 32'(c * 16 + 1 + (c == 2 ? 4 : 0)));
      repeat (32 << c) @(posedge clk_sys);
      apb(1'b1, CTRL_ADDR, 32'h0);
      rdcnt();
      chk(cnt, 32'h7, 32'h9);
    end
    held = cnt;
    repeat (40) @(posedge clk_sys);
    rdcnt();
    chk(cnt, held, held);
    chk(countValue, held, held);
  endtask : t_timer
  task t_wrap;
    setcnt(16'hFFFE);
    apb(1'b1, CTRL_ADDR, 32'h01);
    repeat (40) @(posedge clk_sys);
    apb(1'b1, CTRL_ADDR, 32'h0);
    rdcnt();
    chk(cnt, 32'h7, 32'hA);
    apb(1'b0, FLAG_ADDR, 32'h0);
    chk(rd[0], 32'h1, 32'h1);
    chk(overflowIrq, 32'h0, 32'h0);
    apb(1'b1, ENABLE_ADDR, 32'h1);
    #1 chk(overflowIrq, 32'h1, 32'h1);
    apb(1'b1, FLAG_ADDR, 32'h0);
    #1 chk(overflowIrq, 32'h0, 32'h0);
  endtask : t_wrap
  task t_cmp;
    setcnt(16'h1234);
    @(posedge clk_sys) compareReset <= 1'b1;
    @(posedge clk_sys) compareReset <= 1'b0;
    rdcnt();
    chk(cnt, 32'h0, 32'h0);
    apb(1'b0, FLAG_ADDR, 32'h0);
    chk(rd[0], 32'h0, 32'h0);
    setcnt(16'h1234);
    @(posedge clk_sys) compareReset <= 1'b1;
    apb(1'b1, CNT_LO_ADDR, 32'h55);
    compareReset <= 1'b0;
    rdcnt();
    chk(cnt, 32'h0055, 32'h0055);
  endtask : t_cmp
  task t_ext;
    setcnt(16'h0000);
    apb(1'b1, CTRL_ADDR, 32'h03);
    pulse(1'b0, 4'h5);
    rdcnt();
    chk(cnt, 32'h5, 32'h5);
    apb(1'b1, CTRL_ADDR, 32'h0B);
    chk({oscInPinOe, oscOutPinOe}, 32'h0, 32'h0);
    pulse(1'b0, 4'h3);
    pulse(1'b1, 4'h4);
    apb(1'b1, CTRL_ADDR, 32'h07);
    pulse(1'b0, 4'h2);
    rdcnt();
    chk(cnt, 32'hB, 32'hB);
  endtask : t_ext
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
  // reset, then the scenarios
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; compareReset = 1'b0; go = 1'b0; toOsc = 1'b0; edges = 4'h0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_timer();
    t_wrap();
    t_cmp();
    t_ext();
    print_verdict();
  end
endmodule : tb
